//--- tcc_evt_src.sv
module tcc_evt_src (
    input  wire logic          clk,
    output tcc_pkg::tcc_evt_t  evt
);
    timeunit 1ns;
    timeprecision 1ns;

    initial evt = '0;

    // each pulse lasts one cycle, launched right after an edge
    task automatic fire(input tcc_pkg::tcc_evt_t kind);
        @(posedge clk);
        evt <= kind;
        @(posedge clk);
        evt <= '0;
    endtask
endmodule

//--- tcc_map.svh
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// register indices; byte address is four times the index
`define TCC_IDX_W        16
`define TCC_IDX_CTRL     16'hFE10
`define TCC_IDX_PRESC    16'hFE11
`define TCC_IDX_CNT_LO   16'hFE12
`define TCC_IDX_CNT_HI   16'hFE13
`define TCC_IDX_MATCH_LO 16'hFE14
`define TCC_IDX_MATCH_HI 16'hFE15
`define TCC_IDX_CAP_LO   16'hFE16
`define TCC_IDX_CAP_HI   16'hFE17

// bus address width, enough for the highest byte address
`define TCC_AW           18

// reset values
`define TCC_RST_CTRL     8'h00
`define TCC_RST_PRESC    8'h00
`define TCC_RST_CNT      8'h00
`define TCC_RST_MATCH    8'h00
`define TCC_RST_CAP      8'h00

// bus responses
`define TCC_RESP_OKAY    2'h0
`define TCC_RESP_SLVERR  2'h2

`endif

//--- tcc_pkg.sv
package tcc_pkg;

    // control register layout, msb first
    typedef struct packed {
        logic run_h;
        logic run_l;
        logic long_m;
        logic ext;
        logic flag_h;
        logic ie_h;
        logic flag_l;
        logic ie_l;
    } tcc_ctrl_t;

    // single-cycle detection pulses from the external-interrupt logic
    typedef struct packed {
        logic count;
        logic cap_low;
        logic cap_high;
    } tcc_evt_t;

    typedef enum logic [1:0] {
        TCC_MODE_DUAL8,
        TCC_MODE_T8_C8,
        TCC_MODE_T16,
        TCC_MODE_C16
    } tcc_mode_t;

endpackage

//--- tcc_timer.sv
`include "tcc_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - prescaler counts cycles, matches programmed value
// - prescaler restarts on match or write
// - prescaler runs except in hold mode
// - low run bit starts/stops low byte
// - high run bit starts/stops high byte
// - low byte clock: prescaler or external pulse
// - high byte clock: prescaler or low carry
// - stopped or matched byte clears to zero
// - match on byte, or all sixteen bits
// - buffer follows register when stopped, loads on match
// - mode 0: two prescaled 8-bit timers
// - mode 1: low counts events, high timer
// - mode 2: one prescaled 16-bit timer
// - mode 3: one 16-bit event counter
// - low capture source follows 16-bit select
// - high capture; 16-bit captures both bytes
// - interrupt request at match interval when enabled
// - match flag sticks until software clears
// - 16-bit mode sets both flags together
// - flag and enable request low/high vector
//////////////////////////////////////////////////////////////////////////////

module tcc_timer #(
    parameter int AW = `TCC_AW
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              hold,
    input  wire tcc_pkg::tcc_evt_t evt,
    output logic                   irq_low,
    output logic                   irq_high,
    output tcc_pkg::tcc_mode_t     mode,
    input  wire logic [AW-1:0]     s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AW-1:0]     s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    tcc_pkg::tcc_ctrl_t  ctrl;
    logic [7:0]          prr;
    logic [7:0]          presc;
    logic [7:0]          cnt_l;
    logic [7:0]          cnt_h;
    logic [7:0]          mreg_l;
    logic [7:0]          mreg_h;
    logic [7:0]          buf_l;
    logic [7:0]          buf_h;
    logic [7:0]          cap_l;
    logic [7:0]          cap_h;

    logic [AW-1:0]       aw_addr;
    logic                aw_full;
    logic [7:0]          w_byte;
    logic                w_lane0;
    logic                w_full;
    logic                do_wr;
    logic [`TCC_IDX_W-1:0] wr_idx;
    logic [`TCC_IDX_W-1:0] rd_idx;
    logic                wr_ok;
    logic                rd_ok;
    logic                wr_en;
    logic                wr_ctrl;
    logic                wr_prr;
    logic                wr_ml;
    logic                wr_mh;

    logic                pre_match;
    logic                lo_tick;
    logic                hi_tick;
    logic                run16;
    logic                match16;
    logic                match_l;
    logic                match_h;
    logic                cap_lo_ev;
    logic [7:0]          next_presc;
    logic [7:0]          rd_byte;

    //////////////////////////////////////////////////////////////////////////
    // register bus decode

    function automatic logic mapped(input logic [AW-1:0] a);
        logic [`TCC_IDX_W-1:0] i;
        i = a[AW-1:2];
        mapped = (a[1:0] == 2'h0) && (i >= `TCC_IDX_CTRL) && (i <= `TCC_IDX_CAP_HI);
    endfunction

    assign wr_idx  = aw_addr[AW-1:2];
    assign rd_idx  = s_axi_araddr[AW-1:2];
    assign wr_ok   = mapped(aw_addr);
    assign rd_ok   = mapped(s_axi_araddr);
    assign do_wr   = aw_full && w_full && !s_axi_bvalid;
    // data sits in lane 0; a write without that lane changes nothing
    assign wr_en   = do_wr && wr_ok && w_lane0;
    assign wr_ctrl = wr_en && (wr_idx == `TCC_IDX_CTRL);
    assign wr_prr  = wr_en && (wr_idx == `TCC_IDX_PRESC);
    assign wr_ml   = wr_en && (wr_idx == `TCC_IDX_MATCH_LO);
    assign wr_mh   = wr_en && (wr_idx == `TCC_IDX_MATCH_HI);

    //////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            aw_full       <= 1'b0;
            aw_addr       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_full       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_full       <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b1;
            w_full       <= 1'b0;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_full       <= 1'b1;
            w_byte       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
        end else if (do_wr) begin
            w_full       <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TCC_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read channel, answer one cycle after the address is taken

    always_comb begin
        rd_byte = 8'h00;
        case (rd_idx)
            `TCC_IDX_CTRL:     rd_byte = ctrl;
            `TCC_IDX_PRESC:    rd_byte = prr;
            `TCC_IDX_CNT_LO:   rd_byte = cnt_l;
            `TCC_IDX_CNT_HI:   rd_byte = cnt_h;
            `TCC_IDX_MATCH_LO: rd_byte = mreg_l;
            `TCC_IDX_MATCH_HI: rd_byte = mreg_h;
            `TCC_IDX_CAP_LO:   rd_byte = cap_l;
            `TCC_IDX_CAP_HI:   rd_byte = cap_h;
            default:           rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TCC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
            s_axi_rresp   <= rd_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // prescaler

    // hold freezes the divider, except that a prescale write still restarts it, and with it every prescaled tick
    assign pre_match = !hold && (presc == prr);

    always_comb begin
        next_presc = presc;
        if (wr_prr)
            next_presc = 8'h00;
        else if (hold)
            next_presc = presc;
        else if (pre_match)
            next_presc = 8'h00;
        else
            next_presc = presc + 8'h01;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            presc <= `TCC_RST_PRESC;
        else
            presc <= next_presc;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            prr <= `TCC_RST_PRESC;
        else if (wr_prr)
            prr <= w_byte;
    end

    //////////////////////////////////////////////////////////////////////////
    // count clocks and match detection

    // event pulses are trusted as already synchronous, one cycle each
    assign lo_tick = ctrl.ext ? (evt.count && !hold) : pre_match;
    // in 16-bit mode the run bits are expected equal; both must be set
    assign run16   = ctrl.run_l && ctrl.run_h;
    assign match16 = run16 && lo_tick && ({cnt_h, cnt_l} == {buf_h, buf_l});
    assign hi_tick = ctrl.long_m ? (lo_tick && cnt_l == 8'hFF) : pre_match;

    always_comb begin
        if (ctrl.long_m) begin
            match_l = match16;
            match_h = match16;
        end else begin
            match_l = ctrl.run_l && lo_tick && (cnt_l == buf_l);
            match_h = ctrl.run_h && hi_tick && (cnt_h == buf_h);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // counter bytes

    always_ff @(posedge clk) begin
        if (!rst_n)
            cnt_l <= `TCC_RST_CNT;
        else if (!ctrl.run_l || match_l)
            cnt_l <= 8'h00;
        else if (lo_tick)
            cnt_l <= cnt_l + 8'h01;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            cnt_h <= `TCC_RST_CNT;
        else if (!ctrl.run_h || match_h)
            cnt_h <= 8'h00;
        else if (hi_tick)
            cnt_h <= cnt_h + 8'h01;
    end

    //////////////////////////////////////////////////////////////////////////
    // match registers and their buffers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mreg_l <= `TCC_RST_MATCH;
            mreg_h <= `TCC_RST_MATCH;
        end else begin
            if (wr_ml)
                mreg_l <= w_byte;
            if (wr_mh)
                mreg_h <= w_byte;
        end
    end

    // a running period is never cut short by a new value
    always_ff @(posedge clk) begin
        if (!rst_n)
            buf_l <= `TCC_RST_MATCH;
        else if (!ctrl.run_l || match_l)
            buf_l <= mreg_l;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            buf_h <= `TCC_RST_MATCH;
        else if (!ctrl.run_h || match_h)
            buf_h <= mreg_h;
    end

    //////////////////////////////////////////////////////////////////////////
    // control register; a hardware set beats a software clear

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= `TCC_RST_CTRL;
        end else begin
            if (wr_ctrl)
                ctrl <= w_byte;
            if (match_l)
                ctrl.flag_l <= 1'b1;
            if (match_h)
                ctrl.flag_h <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            mode <= tcc_pkg::TCC_MODE_DUAL8;
        else
            mode <= tcc_pkg::tcc_mode_t'({ctrl.long_m, ctrl.ext});
    end

    //////////////////////////////////////////////////////////////////////////
    // capture; writes to these never reach them

    assign cap_lo_ev = ctrl.long_m ? evt.cap_high : evt.cap_low;

    always_ff @(posedge clk) begin
        if (!rst_n)
            cap_l <= `TCC_RST_CAP;
        else if (cap_lo_ev)
            cap_l <= cnt_l;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            cap_h <= `TCC_RST_CAP;
        else if (evt.cap_high)
            cap_h <= cnt_h;
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt request lines, level while flag and enable are both set

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_low  <= 1'b0;
            irq_high <= 1'b0;
        end else begin
            irq_low  <= ctrl.flag_l && ctrl.ie_l;
            irq_high <= ctrl.flag_h && ctrl.ie_h;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks

    presc_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        !hold && !wr_prr && presc != prr |=> presc == $past(presc) + 8'h01)
        else $error("prescaler did not advance");

    presc_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        pre_match || wr_prr |=> presc == 8'h00)
        else $error("prescaler did not restart");

    presc_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        hold && !wr_prr |-> !pre_match ##1 presc == $past(presc))
        else $error("prescaler moved in hold");

    stop_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl.run_l || !ctrl.run_h |=> (!$past(ctrl.run_l) -> cnt_l == 8'h00)
        && (!$past(ctrl.run_h) -> cnt_h == 8'h00))
        else $error("stopped byte not cleared");

    low_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl.run_l && lo_tick && !match_l |=> cnt_l == $past(cnt_l) + 8'h01)
        else $error("low byte missed a tick");

    buf_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl.run_l ##1 !ctrl.run_l |-> buf_l == $past(mreg_l))
        else $error("low buffer not following register");

    flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        match_l |=> ctrl.flag_l ##1 (ctrl.flag_l || $past(wr_ctrl)))
        else $error("low match flag not set");

    flags_same_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl.long_m && match_l |=> ctrl.flag_l && ctrl.flag_h)
        else $error("16-bit flags not set together");

    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl.flag_h && ctrl.ie_h |=> irq_high)
        else $error("high interrupt not raised");

    cap_both_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl.long_m && evt.cap_high |=> cap_l == $past(cnt_l) && cap_h == $past(cnt_h))
        else $error("16-bit capture not simultaneous");

endmodule

//--- timer_counter_with_capture_test.sv
`include "tcc_map.svh"

module timer_counter_with_capture_test;
    timeunit 1ns;
    timeprecision 1ns;

    localparam tcc_pkg::tcc_evt_t CNT = 3'b100;
    localparam tcc_pkg::tcc_evt_t CPL = 3'b010;
    localparam tcc_pkg::tcc_evt_t CPH = 3'b001;

    logic                clk = 0;
    logic                rst_n = 0;
    logic                hold = 0;
    tcc_pkg::tcc_evt_t   evt;
    logic                irq_low, irq_high;
    tcc_pkg::tcc_mode_t  mode;
    logic [17:0]         awaddr = 0, araddr = 0;
    logic                awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0]         wdata = 0, rdata;
    logic [3:0]          wstrb = 0;
    logic                awready, wready, bvalid, arready, rvalid;
    logic [1:0]          bresp, rresp;
    int                  failures = 0, tests_run = 0, cyc = 0, p;
    logic [31:0]         a, b;

    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    tcc_timer i_dut (.clk(clk), .rst_n(rst_n), .hold(hold), .evt(evt),
        .irq_low(irq_low), .irq_high(irq_high), .mode(mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    tcc_evt_src i_src (.clk(clk), .evt(evt));

    //////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        wstrb   <= 4'hF;
        awvalid <= 1;
        wvalid  <= 1;
        bready  <= 1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 0;
            if (wvalid && wready === 1'b1) wvalid <= 0;
        end while (bvalid !== 1'b1 && n < 200);
        if (bvalid !== 1'b1) chk_val("write answer", 1, bvalid);
        r = bresp;
        bready <= 0;
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1;
        rready  <= 1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 0;
        end while (rvalid !== 1'b1 && n < 200);
        if (rvalid !== 1'b1) chk_val("read answer", 1, rvalid);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    task automatic wrc(input logic [15:0] idx, input logic [7:0] d);
        logic [1:0] r;
        wr(idx, d, r);
        chk_resp("write resp", `TCC_RESP_OKAY, r);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] e, input string what);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx, d, r);
        chk_resp("read resp", `TCC_RESP_OKAY, r);
        chk_val(what, {24'h0, e}, d);
    endtask

    // interval between two rises of an irq, clearing flags in between
    task automatic meas(input bit hi, input logic [7:0] base, output int per);
        int t0, w;
        t0 = 0;
        repeat (2) begin
            wrc(`TCC_IDX_CTRL, base);
            w = 0;
            while ((hi ? irq_high : irq_low) !== 1'b0 && w < 50) begin
                @(posedge clk);
                w++;
            end
            if ((hi ? irq_high : irq_low) !== 1'b0) chk_val("irq drop", 0, hi ? irq_high : irq_low);
            w = 0;
            while ((hi ? irq_high : irq_low) !== 1'b1 && w < 3000) begin
                @(posedge clk);
                w++;
            end
            if ((hi ? irq_high : irq_low) !== 1'b1) chk_val("irq rise", 1, hi ? irq_high : irq_low);
            per = cyc - t0;
            t0 = cyc;
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        summarize;
    end

    initial begin
        logic [1:0] r;
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) rdc(16'hFE10 + i[15:0], 8'h00, "reset value");
        rd(16'hFE18, a, r);
        chk_resp("unmapped read", `TCC_RESP_SLVERR, r);
        wr(16'hFE18, 8'h12, r);
        chk_resp("unmapped write", `TCC_RESP_SLVERR, r);
        $display("test registers done");

        wrc(`TCC_IDX_PRESC, 8'h03);
        wrc(`TCC_IDX_MATCH_LO, 8'h04);
        wrc(`TCC_IDX_MATCH_HI, 8'h01);
        meas(0, 8'hC5, p);
        chk_val("low period", 20, p);
        meas(1, 8'hC5, p);
        chk_val("high period", 8, p);
        wrc(`TCC_IDX_MATCH_LO, 8'h09);
        meas(0, 8'hC5, p);
        chk_val("reloaded period", 40, p);
        $display("test mode 0 done");

        wrc(`TCC_IDX_CTRL, 8'h00);
        wrc(`TCC_IDX_MATCH_LO, 8'hFF);
        wrc(`TCC_IDX_CTRL, 8'h40);
        // let the byte move first, so a frozen count is not just zero
        repeat (20) @(posedge clk);
        hold <= 1;
        repeat (2) @(posedge clk);
        rd(`TCC_IDX_CNT_LO, a, r);
        repeat (40) @(posedge clk);
        rd(`TCC_IDX_CNT_LO, b, r);
        chk_val("count in hold", a, b);
        hold <= 0;
        repeat (40) @(posedge clk);
        rd(`TCC_IDX_CNT_LO, b, r);
        chk_val("count after hold", 1, b != a);
        $display("test hold done");

        wrc(`TCC_IDX_CTRL, 8'h00);
        wrc(`TCC_IDX_PRESC, 8'h00);
        wrc(`TCC_IDX_MATCH_LO, 8'h02);
        wrc(`TCC_IDX_MATCH_HI, 8'h01);
        meas(0, 8'hE5, p);
        chk_val("16-bit period", 259, p);
        chk_val("irq high", 1, irq_high);
        chk_val("mode", tcc_pkg::TCC_MODE_T16, mode);
        rdc(`TCC_IDX_CTRL, 8'hEF, "both flags");
        $display("test mode 2 done");

        wrc(`TCC_IDX_CTRL, 8'h00);
        wrc(`TCC_IDX_CTRL, 8'h51);
        // mode status trails the control write by one edge
        @(posedge clk);
        chk_val("mode", tcc_pkg::TCC_MODE_T8_C8, mode);
        repeat (2) i_src.fire(CNT);
        rdc(`TCC_IDX_CNT_LO, 8'h02, "event count");
        i_src.fire(CPL);
        rdc(`TCC_IDX_CAP_LO, 8'h02, "low capture");
        hold <= 1;
        i_src.fire(CNT);
        hold <= 0;
        rdc(`TCC_IDX_CNT_LO, 8'h02, "count gated");
        wrc(`TCC_IDX_CNT_LO, 8'h55);
        rdc(`TCC_IDX_CNT_LO, 8'h02, "count write");
        wrc(`TCC_IDX_CTRL, 8'h11);
        rdc(`TCC_IDX_CNT_LO, 8'h00, "stopped count");
        wrc(`TCC_IDX_CTRL, 8'h51);
        repeat (3) i_src.fire(CNT);
        rdc(`TCC_IDX_CNT_LO, 8'h00, "count at match");
        rdc(`TCC_IDX_CTRL, 8'h53, "low flag");
        $display("test mode 1 done");

        wrc(`TCC_IDX_CTRL, 8'h00);
        wrc(`TCC_IDX_MATCH_LO, 8'h00);
        wrc(`TCC_IDX_MATCH_HI, 8'h02);
        wrc(`TCC_IDX_CTRL, 8'hF0);
        @(posedge clk);
        chk_val("mode", tcc_pkg::TCC_MODE_C16, mode);
        repeat (259) i_src.fire(CNT);
        i_src.fire(CPH);
        rdc(`TCC_IDX_CAP_LO, 8'h03, "long capture low");
        rdc(`TCC_IDX_CAP_HI, 8'h01, "long capture high");
        i_src.fire(CNT);
        i_src.fire(CPL);
        rdc(`TCC_IDX_CAP_LO, 8'h03, "low capture source");
        rdc(`TCC_IDX_CNT_HI, 8'h01, "high count");
        $display("test mode 3 done");
        summarize;
    end
endmodule
